// *** hdl/pdsc_pkg.sv ***
// constants for the comparator dac slope control block
package pdsc_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    // register offsets
    localparam logic [3:0] REG_SLOPE_CTRL = 4'h0;
    localparam logic [3:0] REG_DAC_CTRL   = 4'h1;
    localparam logic [3:0] REG_DAC_DATA   = 4'h2;
    localparam logic [3:0] REG_SLOPE_RATE = 4'h3;
    localparam logic [3:0] REG_STATUS     = 4'h4;
    // slope control fields
    localparam int STOPA_LSB = 8;
    localparam int STOPB_LSB = 4;
    localparam int START_LSB = 0;
    localparam int SEL_W     = 4;
    // dac control fields
    localparam int MODE_LSB   = 0;
    localparam int DIR_BIT    = 2;
    localparam int INSEL_BIT  = 3;
    localparam int DACOE_BIT  = 4;
    localparam int AMPOE_BIT  = 5;
    localparam int FILT_LSB   = 8;
    localparam int FILT_W     = 4;
    localparam int STRETCH_W  = 3;
    // reset values
    localparam logic [15:0] SLOPE_CTRL_RST = 16'h0000;
    localparam logic [15:0] DAC_CTRL_RST   = 16'h0000;
    localparam logic [15:0] DAC_DATA_RST   = 16'h0000;
    localparam logic [15:0] SLOPE_RATE_RST = 16'h0000;
    // selector codes
    localparam logic [3:0] SEL_LOW  = 4'h0;
    localparam logic [3:0] SEL_HIGH = 4'hf;
    // timing: dac logic clock, system clock and stretch cycles
    localparam int DAC_CLK_MHZ = 500;
    localparam int SYS_CLK_MHZ = 10;
    localparam int STRETCH_CYC = 3;
    typedef enum logic [1:0] {
        PDSC_SLOPE,
        PDSC_HYST,
        PDSC_TRIANGLE,
        PDSC_RSVD
    } pdsc_mode_e;
endpackage

// *** hdl/pdsc_pdm.sv ***
// phase accumulator pulse density modulator
`timescale 1ns/100ps
module pdsc_pdm #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] data_i,
    output logic                  pulse_o
);
    logic [WIDTH-1:0] acc;
    logic [WIDTH-1:0] next_acc;
    logic             pulse;
    logic             next_pulse;

    always_comb begin
        // density = data / 2**WIDTH
        {next_pulse, next_acc} = {1'b0, acc} + {1'b0, data_i};
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            acc   <= '0;
            pulse <= 1'b0;
        end else begin
            acc   <= next_acc;
            pulse <= next_pulse;
        end
    end

    assign pulse_o = pulse;

    a_pdm_carry: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ({1'b0, acc} + {1'b0, data_i}) > (2**WIDTH - 1) |=> pulse)
        else $error("carry did not give a pulse");
    a_pdm_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
        data_i == '0 && $past(data_i) == '0 |=> !pulse)
        else $error("zero data gave a pulse");
endmodule

// *** hdl/pdsc_cmpfilt.sv ***
// comparator output pulse stretcher and digital filter
`timescale 1ns/100ps
module pdsc_cmpfilt #(
    parameter int STRETCH = 3,
    parameter int FW      = 4
) (
    input  wire logic          clk_i,
    input  wire logic          rstn_i,
    input  wire logic          raw_i,
    input  wire logic [FW-1:0] len_i,
    output logic               out_o
);
    logic [7:0]    st_cnt;
    logic [7:0]    next_st_cnt;
    logic          stretched;
    logic [FW-1:0] f_cnt;
    logic [FW-1:0] next_f_cnt;
    logic          out;
    logic          next_out;

    always_comb begin
        // stretch a short high so the filter sees at least STRETCH cycles
        next_st_cnt = raw_i ? 8'(STRETCH) :
                      (st_cnt != 8'h00 ? st_cnt - 8'h01 : 8'h00);
        stretched   = raw_i || st_cnt != 8'h00;
        // output follows only after len_i stable cycles
        next_out    = out;
        next_f_cnt  = '0;
        if (stretched != out) begin
            if (f_cnt >= len_i) begin
                next_out = stretched;
            end else begin
                next_f_cnt = f_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_cnt <= '0;
            f_cnt  <= '0;
            out    <= 1'b0;
        end else begin
            st_cnt <= next_st_cnt;
            f_cnt  <= next_f_cnt;
            out    <= next_out;
        end
    end

    assign out_o = out;

    a_filt_change: assert property (@(posedge clk_i) disable iff (!rstn_i)
        out != $past(out) |-> $past(f_cnt) >= $past(len_i))
        else $error("filter output changed too early");
endmodule

// *** hdl/pdsc_top.sv ***
// comparator dac control: selection, slope unit, pdm and filter
`timescale 1ns/100ps
module pdsc_top
    import pdsc_pkg::*;
#(
    parameter bit IS_SLAVE = 1'b0,
    parameter int DAC_W    = 16
) (
    input  wire logic                       CLOCK_I,
    input  wire logic                       RSTN_I,
    input  wire logic [pdsc_pkg::ADDR_W-1:0] ADDR_I,
    input  wire logic [pdsc_pkg::DATA_W-1:0] WDATA_I,
    input  wire logic                       WR_I,
    input  wire logic                       RD_I,
    output logic [pdsc_pkg::DATA_W-1:0]      RDATA_O,
    input  wire logic [7:0]                 PWM_TRIG1_I,
    input  wire logic [7:0]                 PWM_TRIG2_I,
    input  wire logic [7:0]                 REMOTE_TRIG1_I,
    input  wire logic [7:0]                 REMOTE_TRIG2_I,
    input  wire logic [3:0]                 CMP_OUT_I,
    input  wire logic                       CMP_RAW_I,
    input  wire logic                       AMP_PULSE_I,
    output logic                            CMP_PIN_SEL_O,
    output logic                            PDM_O,
    output logic                            SHARED_DAC_OUTPUT_PIN_O,
    output logic                            CMP_OUT_O,
    output logic                            SLOPE_ACTIVE_O
);
    import pdsc_pkg::*;

    // dac logic clock; the 10 MHz system figure models it
    localparam int DAC_CLK_RATIO = DAC_CLK_MHZ / SYS_CLK_MHZ;

    logic [15:0] slope_ctrl, next_slope_ctrl;
    logic [15:0] dac_ctrl, next_dac_ctrl;
    logic [15:0] dac_data, next_dac_data;
    logic [15:0] slope_rate, next_slope_rate;
    logic [15:0] rdata, next_rdata;
    logic [DAC_W-1:0] dac_val, next_dac_val;
    logic        active, next_active;
    logic        tri_up, next_tri_up;
    logic        start_sel, stop_a, stop_b;
    logic        pdm_pulse, filt_out;
    logic        pin_sel, shared_pin, next_shared_pin;
    pdsc_mode_e  mode;

    // start source: trig1 set local/remote per instance
    function automatic logic pick_start(input logic [3:0] c,
            input logic [7:0] t1, input logic [7:0] t2,
            input logic [7:0] r1, input logic slave);
        logic s;
        s = 1'b0;
        if (c == SEL_HIGH) begin
            s = 1'b1;
        end else if (c >= 4'h1 && c <= 4'h8) begin
            if (slave) begin
                s = t1[3'(c - 4'h1)];
            end else if (c <= 4'h4) begin
                s = t1[3'(c - 4'h1)];
            end else begin
                s = t2[3'(c - 4'h5)];
            end
        end else if (c == 4'hd || c == 4'he) begin
            s = r1[3'(c - 4'hd)];
        end
        return s;
    endfunction

    // stop A source
    function automatic logic pick_stop_a(input logic [3:0] c,
            input logic [7:0] t1, input logic [7:0] t2,
            input logic [7:0] r2, input logic slave);
        logic s;
        s = 1'b0;
        if (c == SEL_HIGH) begin
            s = 1'b1;
        end else if (c >= 4'h1 && c <= 4'h8) begin
            if (slave) begin
                s = t2[3'(c - 4'h1)];
            end else if (c <= 4'h4) begin
                s = t1[3'(c - 4'h1)];
            end else begin
                s = t2[3'(c - 4'h5)];
            end
        end else if (c == 4'hd || c == 4'he) begin
            // master sees slave pwm1/2, slave sees master pwm7/8
            s = slave ? r2[3'(c - 4'h7)] : r2[3'(c - 4'hd)];
        end
        return s;
    endfunction

    // stop B: comparators 0 master1, 1..3 slave1..3
    function automatic logic pick_stop_b(input logic [3:0] c,
            input logic [3:0] cmp, input logic slave);
        logic s;
        s = 1'b0;
        if (c == SEL_HIGH) begin
            s = 1'b1;
        end else if (c >= 4'h1 && c <= 4'h4) begin
            if (slave) begin
                s = (c == 4'h4) ? cmp[0] : cmp[2'(c)];
            end else begin
                s = cmp[2'(c - 4'h1)];
            end
        end
        return s;
    endfunction

    always_comb begin
        start_sel = pick_start(slope_ctrl[START_LSB +: SEL_W], PWM_TRIG1_I,
                               PWM_TRIG2_I, REMOTE_TRIG1_I, IS_SLAVE);
        stop_a    = pick_stop_a(slope_ctrl[STOPA_LSB +: SEL_W], PWM_TRIG1_I,
                               PWM_TRIG2_I, REMOTE_TRIG2_I, IS_SLAVE);
        stop_b    = pick_stop_b(slope_ctrl[STOPB_LSB +: SEL_W], CMP_OUT_I,
                               IS_SLAVE);
        mode      = pdsc_mode_e'(dac_ctrl[MODE_LSB +: 2]);
        pin_sel   = dac_ctrl[INSEL_BIT];
    end

    // register bus
    always_comb begin
        next_slope_ctrl = slope_ctrl;
        next_dac_ctrl   = dac_ctrl;
        next_dac_data   = dac_data;
        next_slope_rate = slope_rate;
        next_rdata      = 16'h0000;
        if (WR_I) begin
            case (ADDR_I)
                REG_SLOPE_CTRL: next_slope_ctrl = WDATA_I;
                REG_DAC_CTRL:   next_dac_ctrl   = WDATA_I;
                REG_DAC_DATA:   next_dac_data   = WDATA_I;
                REG_SLOPE_RATE: next_slope_rate = WDATA_I;
                default:        ;
            endcase
        end
        if (RD_I) begin
            case (ADDR_I)
                REG_SLOPE_CTRL: next_rdata = slope_ctrl;
                REG_DAC_CTRL:   next_rdata = dac_ctrl;
                REG_DAC_DATA:   next_rdata = dac_data;
                REG_SLOPE_RATE: next_rdata = slope_rate;
                REG_STATUS:     next_rdata = {13'h0000, tri_up, filt_out,
                                              active};
                default:        next_rdata = 16'h0000;
            endcase
        end
    end

    // dac value engine
    always_comb begin
        next_active = active;
        next_tri_up = tri_up;
        next_dac_val = dac_val;
        case (mode)
            PDSC_SLOPE: begin
                if (stop_a || stop_b) begin
                    next_active  = 1'b0;
                    next_dac_val = dac_data;
                end else if (start_sel && !active) begin
                    next_active  = 1'b1;
                    next_dac_val = dac_data;
                end else if (active) begin
                    // saturate rather than wrap at the range ends
                    if (dac_ctrl[DIR_BIT]) begin
                        next_dac_val = (dac_val > ~slope_rate) ? '1 :
                                       dac_val + slope_rate;
                    end else begin
                        next_dac_val = (dac_val < slope_rate) ? '0 :
                                       dac_val - slope_rate;
                    end
                end else begin
                    next_dac_val = dac_data;
                end
            end
            PDSC_HYST: begin
                // rate register holds the low threshold
                next_active  = 1'b0;
                next_dac_val = filt_out ? slope_rate : dac_data;
            end
            PDSC_TRIANGLE: begin
                next_active = 1'b1;
                if (tri_up) begin
                    next_dac_val = dac_val + 16'h0001;
                    if (dac_val >= dac_data) next_tri_up = 1'b0;
                end else begin
                    next_dac_val = dac_val - 16'h0001;
                    if (dac_val <= slope_rate) next_tri_up = 1'b1;
                end
            end
            default: begin
                next_active  = 1'b0;
                next_dac_val = dac_data;
            end
        endcase
        // combination of dac and amplifier on one pin
        next_shared_pin = (dac_ctrl[DACOE_BIT] & pdm_pulse)
                        | (dac_ctrl[AMPOE_BIT] & AMP_PULSE_I);
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            slope_ctrl <= SLOPE_CTRL_RST;
            dac_ctrl   <= DAC_CTRL_RST;
            dac_data   <= DAC_DATA_RST;
            slope_rate <= SLOPE_RATE_RST;
            rdata      <= 16'h0000;
            dac_val    <= '0;
            active     <= 1'b0;
            tri_up     <= 1'b1;
            shared_pin <= 1'b0;
        end else begin
            slope_ctrl <= next_slope_ctrl;
            dac_ctrl   <= next_dac_ctrl;
            dac_data   <= next_dac_data;
            slope_rate <= next_slope_rate;
            rdata      <= next_rdata;
            dac_val    <= next_dac_val;
            active     <= next_active;
            tri_up     <= next_tri_up;
            shared_pin <= next_shared_pin;
        end
    end

    pdsc_pdm #(.WIDTH(DAC_W)) u_pdm (
        .clk_i   (CLOCK_I),
        .rstn_i  (RSTN_I),
        .data_i  (dac_val),
        .pulse_o (pdm_pulse)
    );

    pdsc_cmpfilt #(.STRETCH(STRETCH_CYC), .FW(FILT_W)) u_filt (
        .clk_i  (CLOCK_I),
        .rstn_i (RSTN_I),
        .raw_i  (CMP_RAW_I),
        .len_i  (dac_ctrl[FILT_LSB +: FILT_W]),
        .out_o  (filt_out)
    );

    assign RDATA_O                 = rdata;
    assign PDM_O                   = pdm_pulse;
    assign SHARED_DAC_OUTPUT_PIN_O = shared_pin;
    assign CMP_OUT_O               = filt_out;
    assign SLOPE_ACTIVE_O          = active;
    assign CMP_PIN_SEL_O           = dac_ctrl[INSEL_BIT];

    a_stop_ends: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        mode == PDSC_SLOPE && (stop_a || stop_b) |=> !active)
        else $error("slope not ended by stop");
    a_start_slope: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        mode == PDSC_SLOPE && start_sel && !stop_a && !stop_b
        |=> active)
        else $error("slope not started");
    a_sel_reserved: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        slope_ctrl[START_LSB +: SEL_W] inside {4'h9, 4'ha, 4'hb, 4'hc}
        |-> !start_sel)
        else $error("reserved start code not low");
    a_stopa_high: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        slope_ctrl[STOPA_LSB +: SEL_W] == SEL_HIGH |-> stop_a)
        else $error("stop A code f not high");
    a_stopb_low: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        slope_ctrl[STOPB_LSB +: SEL_W] == SEL_LOW |-> !stop_b)
        else $error("stop B code 0 not low");
    a_pin_combine: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        dac_ctrl[AMPOE_BIT] && AMP_PULSE_I |=> shared_pin)
        else $error("shared pin missed amplifier");
    a_slope_up: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        active && mode == PDSC_SLOPE && dac_ctrl[DIR_BIT] && !stop_a
        && !stop_b && $stable(mode) |=> dac_val >= $past(dac_val))
        else $error("upward slope went down");
    a_rd_data: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        RD_I && ADDR_I == REG_SLOPE_CTRL && !WR_I
        |=> rdata == $past(slope_ctrl))
        else $error("slope control read back wrong");
endmodule

// *** sim/pdsc_trig_src.sv ***
// pwm trigger and comparator source model for the slope control block
`timescale 1ns/100ps
module pdsc_trig_src (
    input  wire logic       clk_i,
    output logic      [7:0] trig1_o,
    output logic      [7:0] trig2_o,
    output logic      [7:0] rtrig1_o,
    output logic      [7:0] rtrig2_o,
    output logic      [3:0] cmp_o,
    output logic            raw_o,
    output logic            amp_o
);
    // triggers are levels; idle sources sit low like a stopped pwm
    initial begin
        trig1_o = 8'h00;
        trig2_o = 8'h00;
        rtrig1_o = 8'h00;
        rtrig2_o = 8'h00;
        cmp_o = 4'h0;
        raw_o = 1'b0;
        amp_o = 1'b0;
    end

    task automatic drive_trig(input logic [7:0] a, b, ra, rb,
                              input logic [3:0] c);
        @(posedge clk_i);
        trig1_o <= a;
        trig2_o <= b;
        rtrig1_o <= ra;
        rtrig2_o <= rb;
        cmp_o <= c;
    endtask

    task automatic set_line(input logic raw, input logic amp);
        @(posedge clk_i);
        raw_o <= raw;
        amp_o <= amp;
    endtask
endmodule

// *** sim/pdm_dac_slope_control_bench.sv ***
// self-checking bench for the comparator dac slope control block
`timescale 1ns/100ps
module pdm_dac_slope_control_bench;
    import pdsc_pkg::*;
    logic              clk;
    logic              rstn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic        [7:0] t1, t2, r1, r2;
    logic        [3:0] cmp;
    logic              raw, amp, pin_sel, pdm, pin, cmp_out, active;
    int                miscompares = 0;
    int                n_tests = 0;
    int                cyc = 0;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    pdsc_top #(.IS_SLAVE(1'b0), .DAC_W(16)) i_pdsc_top (
        .CLOCK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PWM_TRIG1_I(t1),
        .PWM_TRIG2_I(t2), .REMOTE_TRIG1_I(r1), .REMOTE_TRIG2_I(r2),
        .CMP_OUT_I(cmp), .CMP_RAW_I(raw), .AMP_PULSE_I(amp),
        .CMP_PIN_SEL_O(pin_sel), .PDM_O(pdm),
        .SHARED_DAC_OUTPUT_PIN_O(pin), .CMP_OUT_O(cmp_out),
        .SLOPE_ACTIVE_O(active));

    pdsc_trig_src i_pdsc_trig_src (
        .clk_i(clk), .trig1_o(t1), .trig2_o(t2), .rtrig1_o(r1),
        .rtrig2_o(r2), .cmp_o(cmp), .raw_o(raw), .amp_o(amp));

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // a hang in any wait loop ends the run here
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic near(input string what, input int seen, input int exp,
                        input int tol);
        chk(what, {31'h0, seen >= exp - tol && seen <= exp + tol}, 32'h1);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a,
                          input logic [15:0] e, input logic [15:0] m);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, {16'h0, rdata & m}, {16'h0, e & m});
    endtask

    // accumulator reference; r steps the value each cycle, saturating
    function automatic int pdm_model(int d0, int r, bit up, int n);
        int acc;
        int v;
        int cnt;
        acc = 0;
        v = d0;
        cnt = 0;
        for (int k = 0; k < n; k++) begin
            acc += v;
            if (acc >= 65536) begin
                cnt++;
                acc -= 65536;
            end
            if (up)
                v = (v + r > 65535) ? 65535 : v + r;
            else
                v = (v < r) ? 0 : v - r;
        end
        return cnt;
    endfunction

    task automatic count(input int n, output int cp, output int cs);
        cp = 0;
        cs = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (pdm === 1'b1) cp++;
            if (pin === 1'b1) cs++;
        end
    endtask

    function automatic logic sel_trig(logic [3:0] c, logic [7:0] a,
                                      logic [7:0] b, logic [7:0] r);
        if (c == 4'hf) return 1'b1;
        if (c >= 4'h1 && c <= 4'h4) return a[c - 4'h1];
        if (c >= 4'h5 && c <= 4'h8) return b[c - 4'h5];
        if (c == 4'hd) return r[0];
        if (c == 4'he) return r[1];
        return 1'b0;
    endfunction

    function automatic logic sel_cmp(logic [3:0] c, logic [3:0] v);
        if (c == 4'hf) return 1'b1;
        if (c >= 4'h1 && c <= 4'h4) return v[c - 4'h1];
        return 1'b0;
    endfunction

    task automatic wait_cmp(input logic v);
        int k;
        k = 0;
        while (cmp_out !== v && k < 300) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk("cmp_out", {31'h0, cmp_out}, {31'h0, v});
    endtask

    initial begin
        int cp, cs, e, dv;
        logic [15:0] d;
        logic ex;
        rstn = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        void'($urandom(65));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            rd_chk("reset", a[3:0], 16'h0000, 16'hffff);
            d = 16'($urandom);
            wr_reg(a[3:0], d);
            rd_chk("regrw", a[3:0], d, a == 1 ? 16'h0f3f : 16'h0fff);
        end
        rd_chk("unmapped", 4'h9, 16'h0000, 16'hffff);
        for (int v = 0; v < 4; v++) begin
            wr_reg(REG_DAC_CTRL, {12'h0, v[0], 1'b0, v[1:0]});
            rd_chk("mode", REG_DAC_CTRL, 16'(v[1:0]), 16'h0003);
            chk("insel", {31'h0, pin_sel}, {31'h0, v[0]});
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            dv = (i == 3) ? int'($urandom % 65536) : i * 32768 - i / 2;
            wr_reg(REG_DAC_DATA, dv[15:0]);
            wr_reg(REG_DAC_CTRL, 16'h0010);
            wr_reg(REG_SLOPE_CTRL, 16'h0f00);
            repeat (4) @(posedge clk);
            count(1024, cp, cs);
            e = pdm_model(dv, 0, 1'b1, 1024);
            near("pdm", cp, e, 1);
            near("pin", cs, e, 1);
        end
        $display("test modulator done");
        for (int up = 0; up < 2; up++) begin
            wr_reg(REG_DAC_DATA, up ? 16'h0000 : 16'hffff);
            wr_reg(REG_SLOPE_RATE, 16'h0020);
            wr_reg(REG_DAC_CTRL, up ? 16'h0014 : 16'h0010);
            wr_reg(REG_SLOPE_CTRL, 16'h0f00);
            wr_reg(REG_SLOPE_CTRL, 16'h000f);
            count(1024, cp, cs);
            e = pdm_model(up ? 0 : 65535, 32, up[0], 1024);
            near("ramp", cp, e, 3);
            chk("active", {31'h0, active}, 32'h1);
        end
        $display("test slope done");
        for (int f = 0; f < 3; f++) begin
            for (int c = 0; c < 16; c++) begin
                i_pdsc_trig_src.drive_trig(8'($urandom), 8'($urandom),
                    8'($urandom), 8'($urandom), 4'($urandom));
                if (f == 0) begin
                    wr_reg(REG_SLOPE_CTRL, 16'h0f00);
                    wr_reg(REG_SLOPE_CTRL, {12'h000, c[3:0]});
                    ex = sel_trig(c[3:0], t1, t2, r1);
                end else if (f == 1) begin
                    wr_reg(REG_SLOPE_CTRL, {4'h0, c[3:0], 8'h0f});
                    ex = !sel_trig(c[3:0], t1, t2, r2);
                end else begin
                    wr_reg(REG_SLOPE_CTRL, {8'h00, c[3:0], 4'hf});
                    ex = !sel_cmp(c[3:0], cmp);
                end
                repeat (4) @(posedge clk);
                #1;
                chk("select", {31'h0, active}, {31'h0, ex});
            end
        end
        $display("test selects done");
        wr_reg(REG_DAC_DATA, 16'h0000);
        wr_reg(REG_SLOPE_CTRL, 16'h0f00);
        i_pdsc_trig_src.set_line(1'b0, 1'b1);
        for (int v = 0; v < 2; v++) begin
            wr_reg(REG_DAC_CTRL, v ? 16'h0020 : 16'h0010);
            repeat (4) @(posedge clk);
            #1;
            chk("amp", {31'h0, pin}, 32'(v));
        end
        $display("test shared pin done");
        wr_reg(REG_DAC_CTRL, 16'h0800);
        i_pdsc_trig_src.set_line(1'b1, 1'b0);
        i_pdsc_trig_src.set_line(1'b0, 1'b0);
        e = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (cmp_out === 1'b1) e++;
        end
        chk("glitch", 32'(e), 32'h0);
        i_pdsc_trig_src.set_line(1'b1, 1'b0);
        wait_cmp(1'b1);
        rd_chk("status", REG_STATUS, 16'h0002, 16'h0002);
        i_pdsc_trig_src.set_line(1'b0, 1'b0);
        wait_cmp(1'b0);
        $display("test comparator filter done");
        final_report();
    end
endmodule
